// ### logic/ccl_pkg.sv
// package for the clock and protect configuration loader
package ccl_pkg;
	// register byte addresses in the configuration space
	localparam logic [23:0] CCL_OSC_SEL_ADDR   = 24'h30_0002;
	localparam logic [23:0] CCL_PLL_SEL_ADDR   = 24'h30_0003;
	localparam logic [23:0] CCL_MON_POSC_ADDR  = 24'h30_0004;
	localparam logic [23:0] CCL_PROT_PAGE_ADDR = 24'h30_0006;
	// avalon word offsets (printed offsets are not multiples of four: index times four)
	localparam logic [7:0] CCL_OFS_OSC_SEL   = 8'h08;
	localparam logic [7:0] CCL_OFS_PLL_SEL   = 8'h0c;
	localparam logic [7:0] CCL_OFS_MON_POSC  = 8'h10;
	localparam logic [7:0] CCL_OFS_PROT_PAGE = 8'h18;
	localparam logic [7:0] CCL_OFS_PROT_CTRL = 8'h1c;
	localparam logic [7:0] CCL_OFS_STATUS    = 8'h20;
	// flash byte indexes of the configuration bytes
	localparam logic [3:0] CCL_FL_OSC_SEL   = 4'h2;
	localparam logic [3:0] CCL_FL_PLL_SEL   = 4'h3;
	localparam logic [3:0] CCL_FL_MON_POSC  = 4'h4;
	localparam logic [3:0] CCL_FL_PROT_PAGE = 4'h6;
	localparam logic [3:0] CCL_FL_PROT_CTRL = 4'h7;
	// field positions
	localparam int CCL_SWITCHOVER_BIT = 7;
	localparam int CCL_CLKOUT_EN_BIT  = 5;
	localparam int CCL_SECONDARY_OSCILLATOR_SEL_BIT   = 3;
	localparam int CCL_PROT_END_BIT   = 1;
	localparam int CCL_PROT_DIS_BIT   = 0;
	// supply reset values and fixed read bits
	localparam logic [7:0] CCL_ONES_RESET   = 8'hff;
	localparam logic [7:0] CCL_OSC_SUPPLY_RESET = 8'hdf;
	localparam logic [7:0] CCL_OSC_FIX1     = 8'h40;
	localparam logic [7:0] CCL_OSC_FIX0     = 8'h10;
	localparam logic [7:0] CCL_MON_FIX1     = 8'hc0;
	localparam logic [7:0] CCL_MON_FIX0     = 8'h0c;
	localparam logic [7:0] CCL_PLL_FIX1     = 8'hf0;
	// oscillator select codes
	typedef enum logic [2:0] {
		CCL_OSC_FRC      = 3'b000,
		CCL_OSC_FRC_PLL  = 3'b001,
		CCL_OSC_PRI      = 3'b010,
		CCL_OSC_PRI_PLL  = 3'b011,
		CCL_OSC_SEC      = 3'b100,
		CCL_OSC_LOW_POWER_RC     = 3'b101,
		CCL_OSC_FRC_DIV16 = 3'b110,
		CCL_OSC_FRC_DIVN = 3'b111
	} ccl_osc_e;
	// primary oscillator modes
	typedef enum logic [1:0] {
		CCL_POSC_EXT = 2'b00,
		CCL_POSC_MS  = 2'b01,
		CCL_POSC_HS  = 2'b10,
		CCL_POSC_OFF = 2'b11
	} ccl_posc_e;
	// pll multiplier choice
	typedef enum logic [2:0] {
		CCL_PLL_96M  = 3'b000,
		CCL_PLL_X4   = 3'b001,
		CCL_PLL_X6   = 3'b010,
		CCL_PLL_X8   = 3'b011,
		CCL_PLL_NONE = 3'b100,
		CCL_PLL_RSVD = 3'b101
	} ccl_pll_e;
	// loader states
	typedef enum logic [1:0] {
		CCL_ST_IDLE = 2'b00,
		CCL_ST_REQ  = 2'b01,
		CCL_ST_DONE = 2'b10
	} ccl_state_e;
	// decoded clock settings
	typedef struct packed {
		ccl_osc_e  oscillator_select;
		logic      switchover_enable;
		logic      clock_output;
		logic      secondary_osc_select;
		ccl_posc_e primary_osc_mode;
		ccl_pll_e  pll_mode;
		logic [3:0] pll_in_div;
		logic      pll_enable_avail;
		logic      clock_switch_en;
		logic      fail_safe_en;
	} ccl_clk_cfg_s;
	// decoded protection settings
	typedef struct packed {
		logic       active;
		logic       from_page;
		logic [7:0] protect_page;
	} ccl_prot_cfg_s;
endpackage : ccl_pkg

// ### logic/ccl_config_loader.sv
// configuration shadow registers loaded from flash with clock and protect decode
// Notes on behaviour
// - switchover bit set enables two-speed start-up
// - clock output only when enabled and primary off/external
// - secondary select: crystal circuit or digital input
// - oscillator codes 000-011 decode fast/primary sources
// - oscillator codes 100-111 decode secondary/rc sources
// - supply reset sets ones; device reset reloads flash
// - settings held off until flash values stored
// - clock output enable holder resets to zero
// - pll code 1111: no pll, enable unavailable
// - pll codes 0000-0111: 96 MHz with input divide
// - monitor field 1x disables switching and monitor
// - 01 switching only; 00 switching plus monitor
// - primary mode: off, high, medium, external clock
// - end select 0 protects page zero through field
// - end select 1 protects field through last page
// - protect page ignored while disable bit set
// - unimplemented bits read fixed values
// - flash changes apply only after next reset
//
// The Avalon-MM slave port is this design's own decision.
module ccl_config_loader
	import ccl_pkg::*;
(
	// clock and resets
	input  wire logic          mclk,
	input  wire logic          reset,
	input  wire logic          supply_reset,
	// flash configuration byte read port
	output logic               flash_rd,
	output logic [3:0]         flash_addr,
	input  wire logic          flash_ack,
	input  wire logic [7:0]    flash_data,
	// avalon-mm slave
	input  wire logic [7:0]    avs_address,
	input  wire logic          avs_read,
	input  wire logic          avs_write,
	input  wire logic [31:0]   avs_writedata,
	input  wire logic [3:0]    avs_byteenable,
	output logic [31:0]        avs_readdata,
	output logic               avs_waitrequest,
	output logic [1:0]         avs_response,
	// decoded outputs
	output ccl_clk_cfg_s       clk_cfg,
	output ccl_prot_cfg_s      prot_cfg,
	output logic               config_loaded,
	output logic               dependent_reset
);

	// shadow bytes
	logic [7:0]  osc_sel_r;          // oscillator select byte
	logic [7:0]  pll_sel_r;          // pll select byte
	logic [7:0]  mon_posc_r;         // monitor and primary mode byte
	logic [7:0]  prot_page_r;        // protect page byte
	logic [7:0]  prot_ctrl_r;        // protect control byte (end, disable)
	ccl_state_e  state_r;            // loader state
	ccl_state_e  state_nxt;          // next loader state
	logic [2:0]  idx_r;              // index into fetch list
	logic        ack_r;              // bus answer pending
	logic        hit;                // mapped address
	logic [7:0]  rd_byte;            // selected read byte
	ccl_clk_cfg_s  clk_nxt;          // decoded clock settings
	ccl_prot_cfg_s prot_nxt;         // decoded protect settings

	// flash index of each fetch step
	function automatic logic [3:0] fetch_addr(input logic [2:0] i);
		unique case (i)
			3'd0:    fetch_addr = CCL_FL_OSC_SEL;
			3'd1:    fetch_addr = CCL_FL_PLL_SEL;
			3'd2:    fetch_addr = CCL_FL_MON_POSC;
			3'd3:    fetch_addr = CCL_FL_PROT_PAGE;
			default: fetch_addr = CCL_FL_PROT_CTRL;
		endcase
	endfunction : fetch_addr

	// loader sequencing: every device reset restarts the fetch
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			CCL_ST_IDLE: state_nxt = CCL_ST_REQ;
			CCL_ST_REQ:
			begin
				// last byte taken ends the load
				if (flash_ack && idx_r == 3'd4)
					state_nxt = CCL_ST_DONE;
			end
			CCL_ST_DONE: state_nxt = CCL_ST_DONE;
			default:     state_nxt = CCL_ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge mclk)
	begin
		if (reset || supply_reset)
			state_r <= CCL_ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// fetch index
	always_ff @(posedge mclk)
	begin
		if (reset || supply_reset)
			idx_r <= 3'd0;
		else if (state_r == CCL_ST_REQ && flash_ack)
			idx_r <= idx_r + 3'd1;
	end

	assign flash_rd   = (state_r == CCL_ST_REQ);
	assign flash_addr = fetch_addr(idx_r);

	// shadow bytes: ones on supply reset, held through device reset until reloaded
	// the clock output holder alone resets to zero so the pin stays quiet
	always_ff @(posedge mclk)
	begin
		if (supply_reset)
		begin
			osc_sel_r   <= CCL_OSC_SUPPLY_RESET;
			pll_sel_r   <= CCL_ONES_RESET;
			mon_posc_r  <= CCL_ONES_RESET;
			prot_page_r <= CCL_ONES_RESET;
			prot_ctrl_r <= CCL_ONES_RESET;
		end
		else if (state_r == CCL_ST_REQ && flash_ack)
		begin
			// only the flash fetch writes these; the bus cannot
			unique case (idx_r)
				3'd0:    osc_sel_r   <= flash_data;
				3'd1:    pll_sel_r   <= flash_data;
				3'd2:    mon_posc_r  <= flash_data;
				3'd3:    prot_page_r <= flash_data;
				default: prot_ctrl_r <= flash_data;
			endcase
		end
	end

	// clock decode from the shadow bytes
	always_comb
	begin
		clk_nxt = '0;
		clk_nxt.oscillator_select    = ccl_osc_e'(osc_sel_r[2:0]);
		clk_nxt.switchover_enable    = osc_sel_r[CCL_SWITCHOVER_BIT];
		clk_nxt.secondary_osc_select = osc_sel_r[CCL_SECONDARY_OSCILLATOR_SEL_BIT];
		clk_nxt.primary_osc_mode     = ccl_posc_e'(mon_posc_r[1:0]);
		// clock output needs the primary oscillator off or in external mode
		clk_nxt.clock_output = osc_sel_r[CCL_CLKOUT_EN_BIT] &&
			(mon_posc_r[1:0] == CCL_POSC_OFF || mon_posc_r[1:0] == CCL_POSC_EXT);
		// switching and monitor
		clk_nxt.clock_switch_en = !mon_posc_r[5];
		clk_nxt.fail_safe_en    = (mon_posc_r[5:4] == 2'b00);
		// pll select decode
		clk_nxt.pll_enable_avail = 1'b1;
		unique case (pll_sel_r[3:0])
			4'b1111:
			begin
				clk_nxt.pll_mode         = CCL_PLL_NONE;
				clk_nxt.pll_enable_avail = 1'b0;
			end
			4'b1110: clk_nxt.pll_mode = CCL_PLL_X8;
			4'b1101: clk_nxt.pll_mode = CCL_PLL_X6;
			4'b1100: clk_nxt.pll_mode = CCL_PLL_X4;
			4'b0000: clk_nxt.pll_in_div = 4'd1;
			4'b0001: clk_nxt.pll_in_div = 4'd2;
			4'b0010: clk_nxt.pll_in_div = 4'd3;
			4'b0011: clk_nxt.pll_in_div = 4'd4;
			4'b0100: clk_nxt.pll_in_div = 4'd5;
			4'b0101: clk_nxt.pll_in_div = 4'd6;
			4'b0110: clk_nxt.pll_in_div = 4'd8;
			4'b0111: clk_nxt.pll_in_div = 4'd12;
			// reserved codes flagged, never expected from flash
			default: clk_nxt.pll_mode = CCL_PLL_RSVD;
		endcase
	end

	// protect decode: field ignored while disabled
	always_comb
	begin
		prot_nxt.active       = !prot_ctrl_r[CCL_PROT_DIS_BIT];
		prot_nxt.from_page    = prot_ctrl_r[CCL_PROT_END_BIT];
		prot_nxt.protect_page = prot_page_r;
	end

	// outputs only take the decode once loading is complete
	always_ff @(posedge mclk)
	begin
		if (reset || supply_reset)
		begin
			clk_cfg         <= '0;
			prot_cfg        <= '0;
			config_loaded   <= 1'b0;
			dependent_reset <= 1'b1;
		end
		else if (state_r == CCL_ST_DONE)
		begin
			clk_cfg         <= clk_nxt;
			prot_cfg        <= prot_nxt;
			config_loaded   <= 1'b1;
			dependent_reset <= 1'b0;
		end
	end

	// read data with fixed unimplemented bits
	always_comb
	begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		unique case (avs_address)
			CCL_OFS_OSC_SEL:   rd_byte = (osc_sel_r | CCL_OSC_FIX1) & ~CCL_OSC_FIX0;
			CCL_OFS_PLL_SEL:   rd_byte = pll_sel_r | CCL_PLL_FIX1;
			CCL_OFS_MON_POSC:  rd_byte = (mon_posc_r | CCL_MON_FIX1) & ~CCL_MON_FIX0;
			CCL_OFS_PROT_PAGE: rd_byte = prot_page_r;
			CCL_OFS_PROT_CTRL: rd_byte = {6'b00_0000, prot_ctrl_r[1:0]};
			CCL_OFS_STATUS:    rd_byte = {6'b00_0000, state_r == CCL_ST_REQ, config_loaded};
			default:           hit = 1'b0;
		endcase
	end

	// avalon answer: one wait cycle, writes are acknowledged and dropped
	always_ff @(posedge mclk)
	begin
		if (reset || supply_reset)
		begin
			ack_r        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			avs_response <= 2'b00;
		end
		else if ((avs_read || avs_write) && !ack_r)
		begin
			ack_r        <= 1'b1;
			avs_readdata <= {24'h00_0000, rd_byte};
			// unmapped addresses and any write answer with slave error
			avs_response <= (hit && avs_read) ? 2'b00 : 2'b10;
		end
		else
			ack_r <= 1'b0;
	end

	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

	// clock output never set before the load completes
	clkout_quiet_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		!config_loaded |-> !clk_cfg.clock_output)
		else $error("clock output active before load");
	// no pll gives no enable control
	pll_none_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded && clk_cfg.pll_mode == CCL_PLL_NONE |-> !clk_cfg.pll_enable_avail)
		else $error("pll enable offered with no pll");
	// fail safe implies switching
	monitor_sw_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		clk_cfg.fail_safe_en |-> clk_cfg.clock_switch_en)
		else $error("monitor on without switching");
	// clock output only with primary off or external
	clkout_mode_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		clk_cfg.clock_output |-> clk_cfg.primary_osc_mode inside {CCL_POSC_OFF, CCL_POSC_EXT})
		else $error("clock output with crystal mode");
	// dependents held in reset until loaded
	dep_hold_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		dependent_reset == !config_loaded)
		else $error("dependent reset mismatch");
	// load finishes two cycles after last byte taken
	load_done_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		flash_rd && flash_ack && idx_r == 3'd4 |-> ##2 config_loaded)
		else $error("load did not complete");
	// writes never change shadow bytes
	no_write_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		avs_write && !flash_rd |=> $stable(prot_page_r) && $stable(osc_sel_r))
		else $error("bus write changed configuration");
	// switchover follows stored bit
	switchover_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded && $past(config_loaded) |->
		clk_cfg.switchover_enable == osc_sel_r[CCL_SWITCHOVER_BIT])
		else $error("switchover not following stored bit");

	// supply reset fills the shadow with ones, clock output holder with zero
	// no disable here: the check must see the reset itself
	supply_ones_a: assert property (
		@(posedge mclk)
		supply_reset |=> osc_sel_r == CCL_OSC_SUPPLY_RESET && pll_sel_r == CCL_ONES_RESET)
		else $error("shadow not filled on supply reset");
	// every release of reset starts a fresh fetch on the next cycle
	reload_start_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		$fell(reset || supply_reset) |=> flash_rd)
		else $error("reload did not start after reset");
	// decoded settings stay at zero while the load runs
	no_early_cfg_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		!config_loaded |-> clk_cfg == '0 && prot_cfg == '0)
		else $error("settings visible before load");
	// shadow bytes move only while a fetch is running
	shadow_hold_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		!flash_rd |=> $stable(pll_sel_r) && $stable(mon_posc_r) && $stable(prot_ctrl_r))
		else $error("shadow changed outside a load");
	// once loaded, settings stay put until the next reset
	cfg_stable_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded && $past(config_loaded) |-> $stable(clk_cfg) && $stable(prot_cfg))
		else $error("settings changed without reset");

	// bus writes are answered with slave error and never land
	write_resp_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		avs_write && !avs_waitrequest |-> avs_response == 2'b10)
		else $error("write not refused");
	// oscillator byte reads bit 6 high and bit 4 low
	osc_fixed_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		avs_read && !avs_waitrequest && avs_address == CCL_OFS_OSC_SEL |->
		avs_readdata[6] && !avs_readdata[4])
		else $error("oscillator byte fixed bits wrong");
	// monitor byte reads bits 7-6 high and bits 3-2 low
	mon_fixed_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		avs_read && !avs_waitrequest && avs_address == CCL_OFS_MON_POSC |->
		avs_readdata[7:6] == 2'b11 && avs_readdata[3:2] == 2'b00)
		else $error("monitor byte fixed bits wrong");

	// enabled clock output with primary off or external must appear
	clkout_on_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded && osc_sel_r[CCL_CLKOUT_EN_BIT] &&
		mon_posc_r[0] == mon_posc_r[1] |-> clk_cfg.clock_output)
		else $error("clock output missing");
	// secondary select follows the stored bit
	secondary_oscillator_sel_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded |-> clk_cfg.secondary_osc_select == osc_sel_r[CCL_SECONDARY_OSCILLATOR_SEL_BIT])
		else $error("secondary select not following stored bit");
	// oscillator code passed through unchanged
	osc_code_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded |-> clk_cfg.oscillator_select == osc_sel_r[2:0])
		else $error("oscillator code mismatch");
	// primary mode passed through unchanged
	posc_mode_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded |-> clk_cfg.primary_osc_mode == mon_posc_r[1:0])
		else $error("primary mode mismatch");
	// upper monitor bit set turns both switching and monitor off
	switch_off_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded && mon_posc_r[5] |-> !clk_cfg.clock_switch_en && !clk_cfg.fail_safe_en)
		else $error("switching not disabled");
	// code 01 gives switching without the monitor
	switch_only_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded && mon_posc_r[5:4] == 2'b01 |->
		clk_cfg.clock_switch_en && !clk_cfg.fail_safe_en)
		else $error("switching only mode wrong");
	// codes with top bit clear pick the 96 MHz pll with a real divider
	pll_div_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded && !pll_sel_r[3] |->
		clk_cfg.pll_mode == CCL_PLL_96M && clk_cfg.pll_in_div != 4'd0)
		else $error("96 MHz pll decode wrong");
	// code 1110 gives the 8x multiplier
	pll_mult_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded && pll_sel_r[3:0] == 4'b1110 |-> clk_cfg.pll_mode == CCL_PLL_X8)
		else $error("8x pll decode wrong");
	// disable bit set leaves protection inactive
	prot_off_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded && prot_ctrl_r[CCL_PROT_DIS_BIT] |-> !prot_cfg.active)
		else $error("protection active while disabled");
	// protected range follows page field and end select
	prot_range_a: assert property (
		@(posedge mclk) disable iff (reset || supply_reset)
		config_loaded |-> prot_cfg.protect_page == prot_page_r &&
		prot_cfg.from_page == prot_ctrl_r[CCL_PROT_END_BIT])
		else $error("protected range mismatch");

endmodule : ccl_config_loader

// ### verif/ccl_flash_model.sv
// flash configuration byte storage that answers the loader's fetches
module ccl_flash_model
	import ccl_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// byte image and answer delay set by the bench
	input  wire logic [63:0] image,
	input  wire logic [1:0]  lag,
	// fetch port
	input  wire logic        flash_rd,
	input  wire logic [3:0]  flash_addr,
	output logic             flash_ack,
	output logic [7:0]       flash_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] wait_r; // cycles waited on the current fetch
	// bytes change only when the bench reprograms the image
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			flash_ack  <= 1'b0;
			wait_r     <= 2'd0;
			flash_data <= 8'h5a; // neutral fill while held in reset
		end
		else if (!flash_rd || flash_ack)
		begin
			flash_ack  <= 1'b0;
			wait_r     <= 2'd0;
			flash_data <= ~flash_data; // toggles so stale data never looks valid
		end
		else if (wait_r >= lag)
		begin
			flash_ack  <= 1'b1;
			flash_data <= image[flash_addr[2:0]*8 +: 8];
		end
		else
			wait_r <= wait_r + 2'd1; // slow answer
	end
endmodule : ccl_flash_model

// ### verif/tb_ccl_config_loader.sv
// self-checking bench for the configuration loader
module tb_ccl_config_loader
	import ccl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic          mclk, reset, supply_reset;
	logic          flash_rd, flash_ack;
	logic [3:0]    flash_addr;
	logic [7:0]    flash_data, avs_address;
	logic          avs_read, avs_write, avs_waitrequest;
	logic [31:0]   avs_writedata, avs_readdata;
	logic [1:0]    avs_response, lag;
	ccl_clk_cfg_s  clk_cfg;
	ccl_prot_cfg_s prot_cfg;
	logic          config_loaded, dependent_reset;
	logic [63:0]   image;
	int            err_total, total_checks;
	ccl_config_loader ccl_config_loader_inst (.mclk(mclk), .reset(reset),
		.supply_reset(supply_reset), .flash_rd(flash_rd), .flash_addr(flash_addr),
		.flash_ack(flash_ack), .flash_data(flash_data), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.clk_cfg(clk_cfg), .prot_cfg(prot_cfg), .config_loaded(config_loaded),
		.dependent_reset(dependent_reset));
	ccl_flash_model ccl_flash_model_inst (.mclk(mclk), .rst(reset | supply_reset),
		.image(image), .lag(lag), .flash_rd(flash_rd), .flash_addr(flash_addr),
		.flash_ack(flash_ack), .flash_data(flash_data));
	// 250 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask : chk
	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		avs_address   <= a;
		avs_read      <= !wr;
		avs_write     <= wr;
		avs_writedata <= 32'h0000_00a5;
		for (n = 0; n < 16; n++)
		begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		d = avs_readdata;
		r = avs_response;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
		if (n == 16)
		begin
			err_total++;
			$display("[ERR] %0t bus timeout", $time);
			end_sim();
		end
	endtask : bus
	// read a register and compare the masked byte
	task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		bus(1'b0, a, d, r);
		chk(r, 2'b00, "read response");
		chk(d[7:0] & m, e, "register byte");
	endtask : rdchk
	// reset, then wait for the load while dependents stay held
	task automatic load(input logic sup, input int cyc);
		int n;
		reset        <= 1'b1;
		supply_reset <= sup;
		repeat (cyc) @(posedge mclk);
		reset        <= 1'b0;
		supply_reset <= 1'b0;
		@(posedge mclk);
		if (sup)
		begin
			rdchk(CCL_OFS_OSC_SEL, 8'hff, 8'hcf);
			rdchk(CCL_OFS_PLL_SEL, 8'hff, 8'hff);
			rdchk(CCL_OFS_STATUS, 8'h03, 8'h02);
		end
		for (n = 0; n < 200 && config_loaded !== 1'b1; n++)
		begin
			@(posedge mclk);
			if (config_loaded !== 1'b1)
			begin
				chk(dependent_reset, 1'b1, "held");
				chk(clk_cfg, 18'h0, "early cfg");
			end
		end
		chk(dependent_reset, 1'b0, "released");
		if (n == 200)
			end_sim();
	endtask : load
	// decode expected from the field tables
	function automatic ccl_clk_cfg_s exp_clk(input logic [7:0] o, p, m);
		logic [3:0]   dv [8] = '{4'd1, 4'd2, 4'd3, 4'd4, 4'd5, 4'd6, 4'd8, 4'd12};
		ccl_clk_cfg_s c;
		c = '0;
		c.oscillator_select    = ccl_osc_e'(o[2:0]);
		c.switchover_enable    = o[7];
		c.clock_output         = o[5] && (m[1:0] == 2'b11 || m[1:0] == 2'b00);
		c.secondary_osc_select = o[3];
		c.primary_osc_mode     = ccl_posc_e'(m[1:0]);
		case (p[3:0])
			4'hf: c.pll_mode = CCL_PLL_NONE;
			4'he: c.pll_mode = CCL_PLL_X8;
			4'hd: c.pll_mode = CCL_PLL_X6;
			4'hc: c.pll_mode = CCL_PLL_X4;
			default:
			begin
				c.pll_mode   = CCL_PLL_96M;
				c.pll_in_div = dv[p[2:0]];
			end
		endcase
		c.pll_enable_avail = (p[3:0] != 4'hf);
		c.clock_switch_en  = !m[5];
		c.fail_safe_en     = (m[5:4] == 2'b00);
		return c;
	endfunction : exp_clk
	// hang guard
	initial
	begin
		repeat (20000) @(posedge mclk);
		err_total++;
		$display("[ERR] %0t run timeout", $time);
		end_sim();
	end
	// main sequence
	initial
	begin
		logic [3:0]  pc [8];
		logic [7:0]  o, p, m, pg, c;
		logic [31:0] d;
		logic [1:0]  r;
		pc = '{4'h0, 4'h3, 4'h5, 4'h7, 4'hf, 4'he, 4'hd, 4'hc};
		reset = 1'b1;
		supply_reset = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		lag = 2'd3;
		image = 64'hffff_ffff_ffff_ffff;
		err_total = 0;
		total_checks = 0;
		load(1'b1, 5);
		for (int i = 0; i < 8; i++)
		begin
			o = {i[0], 1'b0, i[1], 1'b1, i[2], i[2:0]};
			p = {4'h0, pc[i]}; // reserved codes never programmed
			m = {2'b00, i[2:1], 2'b11, i[1:0]};
			pg = 8'h11 * i[7:0];
			c = {6'h3f, i[1:0]};
			image <= {c, pg, 8'hff, m, p, o, 16'hffff};
			lag <= i[1:0];
			load(i == 3, 1);
			chk(clk_cfg, exp_clk(o, p, m), "clk cfg");
			if (c[0])
				chk(prot_cfg.active, 1'b0, "prot off");
			else
				chk(prot_cfg, {1'b1, c[1], pg}, "prot");
			rdchk(CCL_OFS_OSC_SEL, 8'hff, (o | 8'h40) & 8'hef);
			rdchk(CCL_OFS_PLL_SEL, 8'hff, p | 8'hf0);
			rdchk(CCL_OFS_MON_POSC, 8'hff, (m | 8'hc0) & 8'hf3);
			rdchk(CCL_OFS_PROT_PAGE, 8'hff, pg);
			rdchk(CCL_OFS_PROT_CTRL, 8'h03, c[1:0]);
			rdchk(CCL_OFS_STATUS, 8'h03, 8'h01);
			bus(1'b1, CCL_OFS_OSC_SEL, d, r);
			chk(r, 2'b10, "write refused");
			rdchk(CCL_OFS_OSC_SEL, 8'hff, (o | 8'h40) & 8'hef);
		end
		bus(1'b0, 8'h40, d, r);
		chk(r, 2'b10, "unmapped resp");
		chk(d, 32'h0, "unmapped data");
		image <= 64'h0;
		repeat (8) @(posedge mclk);
		chk(clk_cfg, exp_clk(o, p, m), "kept cfg");
		rdchk(CCL_OFS_PLL_SEL, 8'hff, p | 8'hf0);
		load(1'b0, 1);
		chk(clk_cfg, exp_clk(8'h00, 8'h00, 8'h00), "reloaded");
		chk(prot_cfg, 10'h200, "reload prot");
		end_sim();
	end
endmodule : tb_ccl_config_loader
